//--- core/twrs_pkg.sv
// Package for the two-wire register slave: constants, states and carriers.
// Assumes a single 200 MHz core clock domain shared by every user of the package.
package twrs_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int TWRS_REG_AW = 8;
    localparam int TWRS_REG_DW = 16;
    localparam int TWRS_BYTE_W = 8;

    // ------------------------------------------------------------------
    // Bus addresses and special register
    // ------------------------------------------------------------------
    localparam logic [7:0] TWRS_BUS_ADDR_LOW = 8'h90;
    localparam logic [7:0] TWRS_BUS_ADDR_HIGH = 8'hBA;
    localparam logic [7:0] TWRS_BYTE_ACCESS_ADDR = 8'hF1;
    localparam logic TWRS_DIR_READ = 1'h1;

    // ------------------------------------------------------------------
    // Counts and fixed values
    // ------------------------------------------------------------------
    localparam logic [3:0] TWRS_BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] TWRS_CNT_ONE = 4'h1;
    localparam logic [7:0] TWRS_PTR_STEP = 8'h01;
    localparam logic [7:0] TWRS_FILL_BYTE = 8'h00;
    localparam logic [15:0] TWRS_REG_RESET = 16'h0000;
    localparam logic TWRS_LINE_LOW = 1'h0;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        TWRS_IDLE,
        TWRS_ADDR,
        TWRS_ADDR_ACK,
        TWRS_REG,
        TWRS_REG_ACK,
        TWRS_WDATA,
        TWRS_WDATA_ACK,
        TWRS_RDATA,
        TWRS_RACK,
        TWRS_RNEXT,
        TWRS_IGNORE
    } twrs_state_e;

    typedef struct packed {
        logic we;
        logic [7:0] addr;
        logic [15:0] data;
    } twrs_wr_s;

endpackage

//--- core/twrs_reg_mem.sv
// Internal 16-bit register array of the device, one write port and one read port.
// Assumes write requests and read address come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

module twrs_reg_mem
    import twrs_pkg::*;
#(
    parameter int AW = TWRS_REG_AW,
    parameter int DW = TWRS_REG_DW
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic we_in,
    input wire logic [AW-1:0] wr_addr_in,
    input wire logic [DW-1:0] wr_data_in,
    input wire logic [AW-1:0] rd_addr_in,
    output logic [DW-1:0] rd_data_out
);

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic [DW-1:0] mem_reg [0:(1<<AW)-1];

    always_ff @(posedge clk_in) begin
        if (we_in) begin
            mem_reg[wr_addr_in] <= wr_data_in;
        end
    end

    // Read data leave through a register
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rd_data_out <= DW'(TWRS_REG_RESET);
        end else begin
            rd_data_out <= mem_reg[rd_addr_in];
        end
    end

endmodule

`default_nettype wire

//--- core/twrs_slave.sv
// Two-wire serial slave giving a bus master access to 16-bit internal registers.
// Assumes open-drain lines with external pull-ups; the master clock line is
// slow against clk_in and is sampled, not used as a clock.
//
// Notes on behaviour
// - Bus address is 0x90 when select pin XOR invert bit is low, else 0xBA.
// - With write address 0xBA the read address 0xBB is also accepted.
// - Address byte holds seven address bits then the direction bit as LSB.
// - Direction bit 0 asks for a write, 1 asks for a read.
// - A matching address byte is acknowledged.
// - In a write the register address byte follows and is acknowledged.
// - Every received write data byte is acknowledged.
// - Registers are 16 bits, written as two consecutive bytes.
// - Write pointer advances after every 16 data bits.
// - Read pointer advances after every 16 bits sent; the code steps it when the low byte is loaded, after the first 8 bits.
// - A master no-acknowledge ends the read; the device stops driving.
// - Both lines high is idle; only the master makes start and stop.
// - Start is data falling while clock is high.
// - Stop is data rising while clock is high.
// - One bit per clock pulse; data changes only while clock is low.
// - Receiver pulls data low during the acknowledge pulse; sender releases.
// - No-acknowledge is the data line left released during that pulse.
// - Data line is only ever pulled low, open-drain style.
// - A register is written only after all 16 bits arrive.
// - Byte write: upper byte to target, lower byte to byte access register.
// - Byte read: upper byte from target, lower byte from byte access register.
`timescale 1ns/1ps
`default_nettype none

module twrs_slave
    import twrs_pkg::*;
(
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic scl_in,
    input wire logic serial_data_line_in,
    input wire logic address_select_pin_in,
    input wire logic address_invert_bit_in,
    output logic serial_data_line_out,
    output logic serial_data_line_oe_out,
    output twrs_wr_s reg_wr_out,
    output logic busy_out
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic scl_meta;
        logic scl_sync;
        logic scl_prev;
        logic sda_meta;
        logic sda_sync;
        logic sda_prev;
        logic asel_meta;
        logic asel_sync;
        twrs_state_e state;
        logic [3:0] bit_cnt;
        logic [7:0] shift;
        logic [7:0] tx;
        logic low_phase;
        logic rd_dir;
        logic [7:0] ptr;
        logic [7:0] hold_hi;
        logic pend_valid;
        logic [7:0] pend_addr;
        logic [7:0] pend_hi;
        logic [7:0] lo_latch;
        logic sda_o;
        logic sda_oe;
        twrs_wr_s wr;
        logic busy;
    } twrs_regs_s;

    // Synchroniser stages start at the idle line level so no false edge follows reset
    localparam twrs_regs_s TWRS_REGS_RST = '{
        scl_meta: ~TWRS_LINE_LOW,
        scl_sync: ~TWRS_LINE_LOW,
        scl_prev: ~TWRS_LINE_LOW,
        sda_meta: ~TWRS_LINE_LOW,
        sda_sync: ~TWRS_LINE_LOW,
        sda_prev: ~TWRS_LINE_LOW,
        state: TWRS_IDLE,
        wr: '0,
        default: '0
    };

    twrs_regs_s regs_reg;
    twrs_regs_s regs_next;
    logic [15:0] rd_data;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Chooses the address that the bus must present
    function automatic logic [7:0] twrs_bus_addr(input logic sel);
        if (sel) begin
            return TWRS_BUS_ADDR_HIGH;
        end else begin
            return TWRS_BUS_ADDR_LOW;
        end
    endfunction

    // Byte to send for the current phase and pointer
    function automatic logic [7:0] twrs_tx_pick(
        input logic low,
        input logic [7:0] ptr,
        input logic [15:0] data,
        input logic [7:0] latch
    );
        if (ptr == TWRS_BYTE_ACCESS_ADDR) begin
            if (low) begin
                return TWRS_FILL_BYTE;
            end else begin
                return latch;
            end
        end else if (low) begin
            return data[7:0];
        end else begin
            return data[15:8];
        end
    endfunction

    // ------------------------------------------------------------------
    // Register array
    // ------------------------------------------------------------------
    twrs_reg_mem #(
        .AW(TWRS_REG_AW),
        .DW(TWRS_REG_DW)
    ) u_mem (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .we_in(regs_reg.wr.we),
        .wr_addr_in(regs_reg.wr.addr),
        .wr_data_in(regs_reg.wr.data),
        .rd_addr_in(regs_reg.ptr),
        .rd_data_out(rd_data)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        logic scl_rise;
        logic scl_fall;
        logic start_seen;
        logic stop_seen;
        logic [7:0] my_addr;
        logic [7:0] next_byte;
        logic [3:0] cnt_inc;
        scl_rise = 1'b0;
        scl_fall = 1'b0;
        start_seen = 1'b0;
        stop_seen = 1'b0;
        my_addr = TWRS_BUS_ADDR_LOW;
        next_byte = TWRS_FILL_BYTE;
        cnt_inc = TWRS_CNT_ONE;

        regs_next = regs_reg;
        // Two-stage synchronisers, then a third stage for edges
        regs_next.scl_meta = scl_in;
        regs_next.scl_sync = regs_reg.scl_meta;
        regs_next.scl_prev = regs_reg.scl_sync;
        regs_next.sda_meta = serial_data_line_in;
        regs_next.sda_sync = regs_reg.sda_meta;
        regs_next.sda_prev = regs_reg.sda_sync;
        regs_next.asel_meta = address_select_pin_in;
        regs_next.asel_sync = regs_reg.asel_meta;
        regs_next.wr.we = 1'b0;
        // The line is only ever pulled low
        regs_next.sda_o = TWRS_LINE_LOW;

        scl_rise = regs_reg.scl_sync & ~regs_reg.scl_prev;
        scl_fall = ~regs_reg.scl_sync & regs_reg.scl_prev;
        start_seen = regs_reg.scl_sync & regs_reg.scl_prev
            & regs_reg.sda_prev & ~regs_reg.sda_sync;
        stop_seen = regs_reg.scl_sync & regs_reg.scl_prev
            & ~regs_reg.sda_prev & regs_reg.sda_sync;
        my_addr = twrs_bus_addr(regs_reg.asel_sync ^ address_invert_bit_in);
        cnt_inc = regs_reg.bit_cnt + TWRS_CNT_ONE;

        if (start_seen) begin
            // Start or repeated start opens a new address phase
            regs_next.state = TWRS_ADDR;
            regs_next.bit_cnt = '0;
            regs_next.low_phase = 1'b0;
            regs_next.sda_oe = 1'b0;
        end else if (stop_seen) begin
            regs_next.state = TWRS_IDLE;
            regs_next.sda_oe = 1'b0;
        end else begin
            case (regs_reg.state)
                TWRS_ADDR, TWRS_REG, TWRS_WDATA: begin
                    if (scl_rise) begin
                        // Sample while the clock is high
                        regs_next.shift = {regs_reg.shift[6:0], regs_reg.sda_sync};
                        regs_next.bit_cnt = cnt_inc;
                    end else if (scl_fall && regs_reg.bit_cnt == TWRS_BITS_PER_BYTE) begin
                        regs_next.bit_cnt = '0;
                        if (regs_reg.state == TWRS_ADDR) begin
                            // Seven address bits compared, LSB is direction
                            if (regs_reg.shift[7:1] == my_addr[7:1]) begin
                                regs_next.rd_dir = regs_reg.shift[0];
                                regs_next.sda_oe = 1'b1;
                                regs_next.state = TWRS_ADDR_ACK;
                            end else begin
                                regs_next.state = TWRS_IGNORE;
                            end
                        end else if (regs_reg.state == TWRS_REG) begin
                            regs_next.ptr = regs_reg.shift;
                            regs_next.low_phase = 1'b0;
                            regs_next.sda_oe = 1'b1;
                            regs_next.state = TWRS_REG_ACK;
                        end else begin
                            regs_next.sda_oe = 1'b1;
                            regs_next.state = TWRS_WDATA_ACK;
                            if (!regs_reg.low_phase) begin
                                if (regs_reg.ptr == TWRS_BYTE_ACCESS_ADDR
                                    && regs_reg.pend_valid) begin
                                    // Lower byte completes a parked upper byte
                                    regs_next.wr.we = 1'b1;
                                    regs_next.wr.addr = regs_reg.pend_addr;
                                    regs_next.wr.data = {regs_reg.pend_hi, regs_reg.shift};
                                    regs_next.pend_valid = 1'b0;
                                end else begin
                                    // Upper byte is held; the register keeps its value
                                    regs_next.hold_hi = regs_reg.shift;
                                    regs_next.pend_addr = regs_reg.ptr;
                                    regs_next.pend_hi = regs_reg.shift;
                                    regs_next.pend_valid = 1'b1;
                                    regs_next.low_phase = 1'b1;
                                end
                            end else begin
                                // Whole register arrived: commit and advance
                                regs_next.wr.we = 1'b1;
                                regs_next.wr.addr = regs_reg.ptr;
                                regs_next.wr.data = {regs_reg.hold_hi, regs_reg.shift};
                                regs_next.ptr = regs_reg.ptr + TWRS_PTR_STEP;
                                regs_next.low_phase = 1'b0;
                                regs_next.pend_valid = 1'b0;
                            end
                        end
                    end
                end
                TWRS_ADDR_ACK: begin
                    if (scl_fall) begin
                        regs_next.sda_oe = 1'b0;
                        if (regs_reg.rd_dir == TWRS_DIR_READ) begin
                            next_byte = twrs_tx_pick(1'b0, regs_reg.ptr, rd_data,
                                regs_reg.lo_latch);
                            if (regs_reg.ptr != TWRS_BYTE_ACCESS_ADDR) begin
                                regs_next.lo_latch = rd_data[7:0];
                            end
                            regs_next.tx = next_byte;
                            // Pull low for a zero, release for a one
                            regs_next.sda_oe = ~next_byte[7];
                            regs_next.low_phase = 1'b1;
                            regs_next.bit_cnt = '0;
                            regs_next.state = TWRS_RDATA;
                        end else begin
                            regs_next.state = TWRS_REG;
                        end
                    end
                end
                TWRS_REG_ACK, TWRS_WDATA_ACK: begin
                    if (scl_fall) begin
                        regs_next.sda_oe = 1'b0;
                        regs_next.state = TWRS_WDATA;
                    end
                end
                TWRS_RDATA: begin
                    if (scl_fall) begin
                        regs_next.bit_cnt = cnt_inc;
                        if (cnt_inc == TWRS_BITS_PER_BYTE) begin
                            // Release for the master's acknowledge
                            regs_next.sda_oe = 1'b0;
                            regs_next.state = TWRS_RACK;
                        end else begin
                            regs_next.tx = {regs_reg.tx[6:0], 1'b0};
                            regs_next.sda_oe = ~regs_reg.tx[6];
                        end
                    end
                end
                TWRS_RACK: begin
                    if (scl_rise) begin
                        if (regs_reg.sda_sync) begin
                            regs_next.state = TWRS_IGNORE;
                        end else begin
                            regs_next.state = TWRS_RNEXT;
                        end
                    end
                end
                TWRS_RNEXT: begin
                    if (scl_fall) begin
                        next_byte = twrs_tx_pick(regs_reg.low_phase, regs_reg.ptr,
                            rd_data, regs_reg.lo_latch);
                        if (regs_reg.low_phase) begin
                            // Low byte goes out: the word is done
                            regs_next.ptr = regs_reg.ptr + TWRS_PTR_STEP;
                            regs_next.low_phase = 1'b0;
                        end else begin
                            if (regs_reg.ptr != TWRS_BYTE_ACCESS_ADDR) begin
                                regs_next.lo_latch = rd_data[7:0];
                            end
                            regs_next.low_phase = 1'b1;
                        end
                        regs_next.tx = next_byte;
                        regs_next.sda_oe = ~next_byte[7];
                        regs_next.bit_cnt = '0;
                        regs_next.state = TWRS_RDATA;
                    end
                end
                TWRS_IGNORE: begin
                    regs_next.sda_oe = 1'b0;
                end
                default: begin
                    regs_next.sda_oe = 1'b0;
                end
            endcase
        end

        regs_next.busy = (regs_next.state != TWRS_IDLE)
            && (regs_next.state != TWRS_IGNORE);
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            regs_reg <= TWRS_REGS_RST;
        end else begin
            regs_reg <= regs_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign serial_data_line_out = regs_reg.sda_o;
    assign serial_data_line_oe_out = regs_reg.sda_oe;
    assign reg_wr_out = regs_reg.wr;
    assign busy_out = regs_reg.busy;

endmodule

`default_nettype wire

//--- test/twrs_slave_sva.sv
// Checker for the two-wire register slave, bound to the ports of its top module.
// Assumes one clock domain and a bus clock line far slower than clk_in.
`timescale 1ns/1ps
`default_nettype none

module twrs_slave_sva
    import twrs_pkg::*;
(
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic scl_in,
    input wire logic serial_data_line_in,
    input wire logic address_select_pin_in,
    input wire logic address_invert_bit_in,
    input wire logic serial_data_line_out,
    input wire logic serial_data_line_oe_out,
    input wire twrs_wr_s reg_wr_out,
    input wire logic busy_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);

    drive_low_a: assert property (serial_data_line_out == 1'b0)
        else $error("data line driven high");
    drive_when_busy_a: assert property (serial_data_line_oe_out |-> busy_out)
        else $error("data line driven outside a transaction");
    oe_clock_low_a: assert property ($changed(serial_data_line_oe_out)
        |-> !scl_in && !$past(scl_in, 2)) else $error("data drive moved with clock high");
    sync_delay_a: assert property ($fell(scl_in)
        |-> ##1 $stable(serial_data_line_oe_out) [*2]) else $error("clock edge not synchronised");
    ack_stands_a: assert property ($rose(serial_data_line_oe_out)
        |=> serial_data_line_oe_out [*8]) else $error("driven bit dropped early");
    wr_pulse_a: assert property (reg_wr_out.we |=> !reg_wr_out.we)
        else $error("write strobe longer than one cycle");
    wr_with_ack_a: assert property (reg_wr_out.we
        |-> $rose(serial_data_line_oe_out) && busy_out) else $error("write not at byte ack");
    stop_idle_a: assert property ($rose(serial_data_line_in) && scl_in && $past(scl_in)
        |-> ##[1:7] !busy_out) else $error("stop did not end transaction");
    start_release_a: assert property ($fell(serial_data_line_in) && scl_in
        && $past(scl_in) |-> !serial_data_line_oe_out [*8]) else $error("drive after start");
    reset_quiet_a: assert property ($rose(nrst_in) |-> !busy_out
        && !serial_data_line_oe_out && !reg_wr_out.we) else $error("outputs active at reset");
endmodule

bind twrs_slave twrs_slave_sva u_sva (
    .clk_in(clk_in), .nrst_in(nrst_in), .scl_in(scl_in),
    .serial_data_line_in(serial_data_line_in),
    .address_select_pin_in(address_select_pin_in),
    .address_invert_bit_in(address_invert_bit_in),
    .serial_data_line_out(serial_data_line_out),
    .serial_data_line_oe_out(serial_data_line_oe_out),
    .reg_wr_out(reg_wr_out), .busy_out(busy_out)
);
`default_nettype wire

//--- test/twrs_host_model.sv
// Behavioural bus master for the two-wire slave: bits, acks, starts and stops.
// Assumes the bench resolves the open-drain data wire and feeds it back.
`timescale 1ns/1ps
`default_nettype none

module twrs_host_model (
    output logic scl_out,
    output logic sda_oe_out,
    input wire logic sda_in
);
    initial begin
        scl_out = 1'b1;
        sda_oe_out = 1'b0;
    end
    // 48 ns bit: low 36 ns with data moved 20 ns in, then high 12 ns
    task automatic bit_out(input logic b);
        #20 sda_oe_out = !b;
        #16 scl_out = 1'b1;
        #12 scl_out = 1'b0;
    endtask
    task automatic bit_in(output logic b);
        #20 sda_oe_out = 1'b0;
        #16 scl_out = 1'b1;
        #6 b = sda_in;
        #6 scl_out = 1'b0;
    endtask
    task automatic start_c;
        #20 sda_oe_out = 1'b0;
        #16 scl_out = 1'b1;
        #12 sda_oe_out = 1'b1;
        #12 scl_out = 1'b0;
    endtask
    task automatic stop_c;
        #20 sda_oe_out = 1'b1;
        #16 scl_out = 1'b1;
        #12 sda_oe_out = 1'b0;
        #24;
    endtask
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--) begin
            bit_out(b[i]);
        end
        bit_in(a);
        ack = !a;
    endtask
    task automatic rbyte(output logic [7:0] b, input logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_in(b[i]);
        end
        bit_out(!ack);
    endtask
endmodule
`default_nettype wire

//--- test/tb.sv
// Self-checking bench for the two-wire register slave against a bus master model.
// Assumes a pull-up on the data line; the bench resolves the open-drain wire.
`timescale 1ns/1ps
`default_nettype none

module tb
    import twrs_pkg::*;
;
    logic clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic sel = 1'b0;
    logic inv = 1'b0;
    logic scl;
    logic h_oe;
    logic d_oe;
    logic d_out;
    logic busy;
    wire logic sda;
    twrs_wr_s wr;
    twrs_wr_s wq[$];
    int err_count = 0;
    int compares = 0;
    int cycles = 0;

    assign sda = !h_oe && (d_oe ? d_out : 1'b1);
    always #2.5 clk_in = !clk_in;

    twrs_slave DUT (
        .clk_in(clk_in), .nrst_in(nrst_in), .scl_in(scl), .serial_data_line_in(sda),
        .address_select_pin_in(sel), .address_invert_bit_in(inv),
        .serial_data_line_out(d_out), .serial_data_line_oe_out(d_oe),
        .reg_wr_out(wr), .busy_out(busy)
    );
    twrs_host_model host (.scl_out(scl), .sda_oe_out(h_oe), .sda_in(sda));

    always @(negedge clk_in) begin
        if (wr.we === 1'b1) wq.push_back(wr);
        cycles++;
        if (cycles == 40000) begin
            err_count++;
            print_verdict();
        end
    end

    task automatic print_verdict;
        $display("Checks %0d, mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %0t: got %0h, expected %0h", $time, seen, exp);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(negedge clk_in);
        #1;
    endtask
    task automatic send(input logic [7:0] b, input logic exp);
        logic a;
        host.wbyte(b, a);
        check(a, exp);
    endtask
    task automatic recv(input logic [7:0] exp, input logic ack);
        logic [7:0] d;
        host.rbyte(d, ack);
        check(d, exp);
    endtask
    task automatic wr_exp(input logic [7:0] a, input logic [15:0] d);
        twrs_wr_s w;
        w = '0;
        if (wq.size() > 0) w = wq.pop_front();
        check({w.addr, w.data}, {a, d});
    endtask
    task automatic wr_to(input logic [7:0] r);
        host.start_c();
        send(8'h90, 1'b1);
        send(r, 1'b1);
    endtask
    task automatic rd_from(input logic [7:0] r);
        wr_to(r);
        host.start_c();
        send(8'h91, 1'b1);
    endtask

    // Two words, ended by a repeated start, then read back with pointer steps
    task automatic t_write_read;
        wr_to(8'h09);
        send(8'h02, 1'b1);
        send(8'h84, 1'b1);
        send(8'h12, 1'b1);
        send(8'h34, 1'b1);
        rd_from(8'h09);
        recv(8'h02, 1'b1);
        recv(8'h84, 1'b1);
        recv(8'h12, 1'b1);
        recv(8'h34, 1'b0);
        host.stop_c();
        settle(4);
        wr_exp(8'h09, 16'h0284);
        wr_exp(8'h0A, 16'h1234);
        check(busy, 1'b0);
        check(d_oe, 1'b0);
    endtask

    // Every select/invert pairing, matching and foreign addresses
    task automatic t_addr;
        logic hi;
        for (int i = 0; i < 4; i++) begin
            @(negedge clk_in);
            sel = i[1];
            inv = i[0];
            settle(4);
            hi = sel ^ inv;
            host.start_c();
            send(hi ? 8'hBA : 8'h90, 1'b1);
            if (hi) begin
                send(8'h09, 1'b1);
                host.start_c();
                send(8'hBB, 1'b1);
                recv(8'h02, 1'b0);
            end
            host.stop_c();
            host.start_c();
            send(hi ? 8'h90 : 8'hBA, 1'b0);
            send(8'h09, 1'b0);
            send(8'h55, 1'b0);
            host.stop_c();
        end
        check(wq.size(), 0);
        @(negedge clk_in);
        sel = 1'b0;
        inv = 1'b0;
        settle(4);
    endtask

    // Lone bytes never commit; byte-wide write and read via the access register
    task automatic t_bytes;
        wr_to(8'h0A);
        send(8'h77, 1'b1);
        host.stop_c();
        rd_from(8'h0A);
        recv(8'h12, 1'b1);
        recv(8'h34, 1'b0);
        host.stop_c();
        wr_to(8'h20);
        send(8'hAB, 1'b1);
        host.stop_c();
        check(wq.size(), 0);
        wr_to(TWRS_BYTE_ACCESS_ADDR);
        send(8'hCD, 1'b1);
        host.stop_c();
        wr_exp(8'h20, 16'hABCD);
        rd_from(8'h20);
        recv(8'hAB, 1'b0);
        host.stop_c();
        rd_from(TWRS_BYTE_ACCESS_ADDR);
        recv(8'hCD, 1'b0);
        host.stop_c();
        check(wq.size(), 0);
    endtask

    initial begin
        repeat (4) @(negedge clk_in);
        nrst_in = 1'b1;
        settle(4);
        t_write_read();
        t_addr();
        t_bytes();
        print_verdict();
    end
endmodule
`default_nettype wire
